//--- rtl/acfr_pkg.sv
package acfr_pkg;

  localparam int NUM_CH = 4;
  localparam int REG_W  = 8;
  localparam int CODE_W = 3;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_PAIR_A       = 8'h0d;
  localparam logic [7:0] ADDR_PAIR_B       = 8'h0e;
  localparam logic [7:0] ADDR_CH_FAULT_MEM = 8'h0f;
  localparam logic [7:0] ADDR_SUPPLY_MEM   = 8'h10;
  localparam logic [7:0] ADDR_SUPPLY_LIVE  = 8'h11;
  localparam logic [7:0] ADDR_THERMAL_MEM  = 8'h12;
  localparam logic [7:0] ADDR_FAULT_CLEAR  = 8'h30;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] PAIR_RESET = 8'h24;
  localparam logic [7:0] MEM_RESET  = 8'h00;
  localparam logic [7:0] LIVE_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED   = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int OC_BASE        = 4;
  localparam int DC_BASE        = 0;
  localparam int SUP_GATE_BIT   = 5;
  localparam int SUP_POR_BIT    = 4;
  localparam int SUP_PS_HIGH    = 3;
  localparam int SUP_BAT_HIGH   = 2;
  localparam int SUP_PS_LOW     = 1;
  localparam int SUP_BAT_LOW    = 0;
  localparam int LIVE_WARN_BIT  = 7;
  localparam int LIVE_FAULT_BIT = 6;

  // ****************************************
  // Channel state codes
  // ****************************************
  typedef enum logic [2:0] {
    ST_PLAY                     = 3'h0,
    ST_HIGH_IMPEDANCE           = 3'h1,
    ST_MUTE                     = 3'h2,
    ST_DIAGNOSTIC               = 3'h3,
    ST_AUTO_RECOVER_SHUTDOWN    = 3'h4,
    ST_LATCHED_PROTECT_SHUTDOWN = 3'h5
  } acfr_chan_state_type;

endpackage

//--- rtl/acfr_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
interface acfr_mem_if;
  logic [acfr_pkg::REG_W-1:0] event_set;
  logic                       read_clr;
  logic [acfr_pkg::REG_W-1:0] stored;
  modport owner    (output event_set, output read_clr, input stored);
  modport mem_side (input event_set, input read_clr, output stored);
endinterface
`default_nettype wire

//--- rtl/acfr_event_mem.sv
`timescale 1ns/1ps
`default_nettype none
module acfr_event_mem (
  input  wire logic     i_clk,
  input  wire logic     i_sys_rst,
  acfr_mem_if.mem_side  mem
);

  logic [acfr_pkg::REG_W-1:0] mem_q;
  logic [acfr_pkg::REG_W-1:0] mem_d;

  // ****************************************
  // Sticky store
  // ****************************************
  // set beats clear
  assign mem_d      = (mem_q & {acfr_pkg::REG_W{~mem.read_clr}}) | mem.event_set;
  assign mem.stored = mem_q;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mem_q <= acfr_pkg::MEM_RESET;
    end else begin
      mem_q <= mem_d;
    end
  end

  a_set_wins_clear: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (mem.event_set != '0) |=> ((mem.stored & $past(mem.event_set)) == $past(mem.event_set)))
    else $error("event lost in memory");

  a_sticky_until_read: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    !mem.read_clr |=> ((mem.stored & $past(mem.stored)) == $past(mem.stored)))
    else $error("memory bit dropped without read");

endmodule // acfr_event_mem
`default_nettype wire

//--- rtl/acfr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module acfr_regs (
  input  wire logic                                        i_clk,
  input  wire logic                                        i_sys_rst,
  input  wire logic                                        i_rd_en,
  input  wire logic                                        i_wr_en,
  input  wire logic [7:0]                                  i_addr,
  output logic      [7:0]                                  o_rd_data,
  output logic                                             o_rd_valid,
  input  wire logic [acfr_pkg::NUM_CH*acfr_pkg::CODE_W-1:0] i_channel_state_code,
  input  wire logic [acfr_pkg::NUM_CH-1:0]                 i_diagnostic_state_pass_flag,
  input  wire logic [acfr_pkg::NUM_CH-1:0]                 i_overcurrent_event,
  input  wire logic [acfr_pkg::NUM_CH-1:0]                 i_offset_fault_event,
  input  wire logic                                        i_gate_drive_supply_fault,
  input  wire logic                                        i_digital_core_supply_por,
  input  wire logic                                        i_power_stage_supply_high,
  input  wire logic                                        i_battery_supply_high,
  input  wire logic                                        i_power_stage_supply_low,
  input  wire logic                                        i_battery_supply_low,
  input  wire logic                                        i_any_warning,
  input  wire logic                                        i_any_fault,
  input  wire logic [7:0]                                  i_thermal_fault_memory,
  output logic      [acfr_pkg::NUM_CH-1:0]                 o_restart_hold
);

  localparam int NCH = acfr_pkg::NUM_CH;
  localparam int CW  = acfr_pkg::CODE_W;

  // ****************************************
  // Declarations
  // ****************************************
  logic [CW-1:0]  code_q [NCH];
  logic [NCH-1:0] pass_q;
  logic [NCH-1:0] hold_q;
  logic [NCH-1:0] hold_d;
  logic [7:0]     live_q;
  logic [7:0]     live_d;
  logic [7:0]     rd_data_q;
  logic [7:0]     rd_data_d;
  logic           rd_valid_q;
  logic [7:0]     pair_a_w;
  logic [7:0]     pair_b_w;
  logic [7:0]     ch_evt_w;
  logic [7:0]     sup_evt_w;
  logic           hit_pair_a;
  logic           hit_pair_b;
  logic           hit_ch_mem;
  logic           hit_sup_mem;
  logic           hit_live;
  logic           hit_thermal;
  logic           clear_wr;

  acfr_mem_if ch_if ();
  acfr_mem_if sup_if ();

  // ****************************************
  // Address decode
  // ****************************************
  assign hit_pair_a  = i_rd_en && (i_addr == acfr_pkg::ADDR_PAIR_A);
  assign hit_pair_b  = i_rd_en && (i_addr == acfr_pkg::ADDR_PAIR_B);
  assign hit_ch_mem  = i_rd_en && (i_addr == acfr_pkg::ADDR_CH_FAULT_MEM);
  assign hit_sup_mem = i_rd_en && (i_addr == acfr_pkg::ADDR_SUPPLY_MEM);
  assign hit_live    = i_rd_en && (i_addr == acfr_pkg::ADDR_SUPPLY_LIVE);
  assign hit_thermal = i_rd_en && (i_addr == acfr_pkg::ADDR_THERMAL_MEM);
  assign clear_wr    = i_wr_en && (i_addr == acfr_pkg::ADDR_FAULT_CLEAR);

  // ****************************************
  // Per channel state, memory mapping, hold
  // ****************************************
  generate
    for (genvar c = 0; c < NCH; c++) begin : g_ch
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          code_q[c] <= acfr_pkg::ST_HIGH_IMPEDANCE;
          pass_q[c] <= 1'b0;
        end else begin
          code_q[c] <= i_channel_state_code[c*CW +: CW];
          pass_q[c] <= i_diagnostic_state_pass_flag[c];
        end
      end

      assign ch_evt_w[acfr_pkg::OC_BASE + NCH - 1 - c] = i_overcurrent_event[c];
      assign ch_evt_w[acfr_pkg::DC_BASE + NCH - 1 - c] = i_offset_fault_event[c];

      assign hold_d[c] = (hold_q[c] & ~clear_wr)
                       | i_overcurrent_event[c]
                       | i_offset_fault_event[c];
    end
  endgenerate

  assign pair_a_w = {code_q[0], code_q[1], pass_q[0], pass_q[1]};
  assign pair_b_w = {code_q[2], code_q[3], pass_q[2], pass_q[3]};

  // A fault that is still present keeps the hold set even across a clear write
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      hold_q <= '0;
    end else begin
      hold_q <= hold_d;
    end
  end

  assign o_restart_hold = hold_q;

  // ****************************************
  // Event memories
  // ****************************************
  // supply memory layout
  assign sup_evt_w[7:6]                    = 2'h0;
  assign sup_evt_w[acfr_pkg::SUP_GATE_BIT] = i_gate_drive_supply_fault;
  assign sup_evt_w[acfr_pkg::SUP_POR_BIT]  = i_digital_core_supply_por;
  assign sup_evt_w[acfr_pkg::SUP_PS_HIGH]  = i_power_stage_supply_high;
  assign sup_evt_w[acfr_pkg::SUP_BAT_HIGH] = i_battery_supply_high;
  assign sup_evt_w[acfr_pkg::SUP_PS_LOW]   = i_power_stage_supply_low;
  assign sup_evt_w[acfr_pkg::SUP_BAT_LOW]  = i_battery_supply_low;

  assign ch_if.event_set  = ch_evt_w;
  assign sup_if.event_set = sup_evt_w;
  assign ch_if.read_clr   = hit_ch_mem;
  assign sup_if.read_clr  = hit_sup_mem;

  acfr_event_mem u_ch_mem (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .mem       (ch_if)
  );

  acfr_event_mem u_sup_mem (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .mem       (sup_if)
  );

  // ****************************************
  // Live supply status
  // ****************************************
  // global warning
  assign live_d[acfr_pkg::LIVE_WARN_BIT]  = i_any_warning;
  assign live_d[acfr_pkg::LIVE_FAULT_BIT] = i_any_fault;
  assign live_d[acfr_pkg::SUP_GATE_BIT]   = i_gate_drive_supply_fault;
  assign live_d[acfr_pkg::SUP_POR_BIT]    = 1'b0;
  assign live_d[acfr_pkg::SUP_PS_HIGH]    = i_power_stage_supply_high;
  assign live_d[acfr_pkg::SUP_BAT_HIGH]   = i_battery_supply_high;
  assign live_d[acfr_pkg::SUP_PS_LOW]     = i_power_stage_supply_low;
  assign live_d[acfr_pkg::SUP_BAT_LOW]    = i_battery_supply_low;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      live_q <= acfr_pkg::LIVE_RESET;
    end else begin
      live_q <= live_d;
    end
  end

  // ****************************************
  // Read return
  // ****************************************
  // Memories are sampled before the clear lands, so the read sees the old content
  assign rd_data_d = hit_pair_a  ? pair_a_w      :
                     hit_pair_b  ? pair_b_w      :
                     hit_ch_mem  ? ch_if.stored  :
                     hit_sup_mem ? sup_if.stored :
                     hit_live    ? live_q        :
                     hit_thermal ? i_thermal_fault_memory :
                                   acfr_pkg::UNMAPPED;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rd_data_q  <= acfr_pkg::UNMAPPED;
      rd_valid_q <= 1'b0;
    end else begin
      rd_data_q  <= i_rd_en ? rd_data_d : rd_data_q;
      rd_valid_q <= i_rd_en;
    end
  end

  assign o_rd_data  = rd_data_q;
  assign o_rd_valid = rd_valid_q;

  // ****************************************
  // Checks
  // ****************************************
  // reset value check
  a_pair_reset_value: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    $fell(i_sys_rst) |->
      (pair_a_w == acfr_pkg::PAIR_RESET) && (pair_b_w == acfr_pkg::PAIR_RESET))
    else $error("pair state register not at reset value");

  a_code_tracks_state: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    !$past(i_sys_rst) |->
      (pair_a_w[7:5] == $past(i_channel_state_code[2:0]))
      && (pair_b_w[4:2] == $past(i_channel_state_code[11:9])))
    else $error("channel state code mismatch");

  a_pair_read_data: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    hit_pair_a |=> o_rd_valid && (o_rd_data == $past(pair_a_w)))
    else $error("pair register read wrong");

  a_diagnostic_state_pass_bits: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    !$past(i_sys_rst) |->
      (pair_b_w[1:0] == $past({i_diagnostic_state_pass_flag[2], i_diagnostic_state_pass_flag[3]})))
    else $error("diagnostic pass bits wrong");

  a_read_clears_mem: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    hit_ch_mem |=> (ch_if.stored == $past(ch_evt_w)))
    else $error("channel fault memory not cleared by read");

  a_supply_read_clear: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (hit_sup_mem && (sup_evt_w == 8'h00)) |=> (sup_if.stored == 8'h00))
    else $error("supply memory not cleared by read");

  a_restart_hold_keep: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (o_restart_hold[0] && !clear_wr) |=> o_restart_hold[0])
    else $error("restart hold dropped without clear write");

  a_restart_hold_set: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_overcurrent_event[1] || i_offset_fault_event[1]) |=> o_restart_hold[1])
    else $error("restart hold not set by fault");

  a_oc_bit_order: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_overcurrent_event[0] |=> ch_if.stored[7])
    else $error("channel 1 over-current not stored in bit 7");

  a_dc_bit_order: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_offset_fault_event[3] |=> ch_if.stored[0])
    else $error("channel 4 offset fault not stored in bit 0");

  a_supply_mem_layout: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_gate_drive_supply_fault |=> sup_if.stored[5] && (sup_if.stored[7:6] == 2'h0))
    else $error("supply memory layout wrong");

  a_live_supply_bits: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    !$past(i_sys_rst) |->
      (live_q[3:0] == $past({i_power_stage_supply_high, i_battery_supply_high,
                             i_power_stage_supply_low, i_battery_supply_low})))
    else $error("live supply bits wrong");

  a_global_warning: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_any_warning ##1 hit_live |=> o_rd_data[7])
    else $error("global warning not reported");

  a_global_fault: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    !$past(i_sys_rst) |-> (live_q[6] == $past(i_any_fault)))
    else $error("global fault flag wrong");

  a_gate_and_reserved: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    !$past(i_sys_rst) |-> (live_q[5] == $past(i_gate_drive_supply_fault)) && !live_q[4])
    else $error("gate drive or reserved bit wrong");

  a_event_during_read: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (hit_ch_mem && i_overcurrent_event[3]) |=> ch_if.stored[4])
    else $error("event during clearing read lost");

  a_mid_code_tracks: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    !$past(i_sys_rst) |->
      (pair_a_w[4:2] == $past(i_channel_state_code[5:3]))
      && (pair_b_w[7:5] == $past(i_channel_state_code[8:6])))
    else $error("channel state code mismatch on second or third channel");

  a_pair_b_read_data: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    hit_pair_b |=> o_rd_valid && (o_rd_data == $past(pair_b_w)))
    else $error("second pair register read wrong");

  a_pair_a_pass_bits: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    !$past(i_sys_rst) |->
      (pair_a_w[1:0] == $past({i_diagnostic_state_pass_flag[0], i_diagnostic_state_pass_flag[1]})))
    else $error("first pair diagnostic pass bits wrong");

  a_ch_mem_read_data: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    hit_ch_mem |=> o_rd_valid && (o_rd_data == $past(ch_if.stored)))
    else $error("channel fault memory read wrong");

  a_sup_mem_read_data: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    hit_sup_mem |=> o_rd_valid && (o_rd_data == $past(sup_if.stored)))
    else $error("supply fault memory read wrong");

  a_restart_hold_clear: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (clear_wr && !i_overcurrent_event[0] && !i_offset_fault_event[0]) |=> !o_restart_hold[0])
    else $error("restart hold not released by clear write");

  a_dc_second_channel: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_offset_fault_event[1] |=> ch_if.stored[2])
    else $error("channel 2 offset fault not stored in bit 2");

  a_live_read_data: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    hit_live |=> o_rd_valid && (o_rd_data == $past(live_q)))
    else $error("live supply status read wrong");

  a_oc_third_channel: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_overcurrent_event[2] |=> ch_if.stored[5])
    else $error("channel 3 over-current not stored in bit 5");

endmodule // acfr_regs
`default_nettype wire

//--- bench/acfr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module acfr_host_model (
  input  wire logic       i_clk,
  output logic            o_rd_en,
  output logic            o_wr_en,
  output logic [7:0]      o_addr,
  input  wire logic [7:0] i_rd_data,
  input  wire logic       i_rd_valid
);
  // ****************************************
  // Host register access
  // ****************************************
  initial begin
    o_rd_en = 1'b0;
    o_wr_en = 1'b0;
    o_addr  = 8'h00;
  end

  // Address flips when idle so a stale decode is never masked
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge i_clk);
    #1;
    o_rd_en = 1'b1;
    o_addr  = a;
    @(posedge i_clk);
    #1;
    o_rd_en = 1'b0;
    o_addr  = ~a;
    d       = i_rd_data;
    v       = i_rd_valid;
  endtask

  task automatic wr(input logic [7:0] a);
    @(posedge i_clk);
    #1;
    o_wr_en = 1'b1;
    o_addr  = a;
    @(posedge i_clk);
    #1;
    o_wr_en = 1'b0;
    o_addr  = ~a;
  endtask
endmodule // acfr_host_model
`default_nettype wire

//--- bench/tb_amp_channel_fault_report_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_amp_channel_fault_report_regs;
  logic        i_clk;
  logic        i_sys_rst;
  logic        rd_en;
  logic        wr_en;
  logic [7:0]  addr;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic [11:0] codes;
  logic [3:0]  diagnostic_state;
  logic [3:0]  oc_ev;
  logic [3:0]  dc_ev;
  logic [5:0]  sup;
  logic        warn;
  logic        flt;
  logic [7:0]  therm;
  logic [3:0]  hold;
  int          n_errors;
  int          num_checks;

  // ****************************************
  // Instances
  // ****************************************
  acfr_regs dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_rd_en(rd_en), .i_wr_en(wr_en),
    .i_addr(addr), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
    .i_channel_state_code(codes), .i_diagnostic_state_pass_flag(diagnostic_state),
    .i_overcurrent_event(oc_ev), .i_offset_fault_event(dc_ev),
    .i_gate_drive_supply_fault(sup[5]), .i_digital_core_supply_por(sup[4]),
    .i_power_stage_supply_high(sup[3]), .i_battery_supply_high(sup[2]),
    .i_power_stage_supply_low(sup[1]), .i_battery_supply_low(sup[0]),
    .i_any_warning(warn), .i_any_fault(flt), .i_thermal_fault_memory(therm),
    .o_restart_hold(hold)
  );

  acfr_host_model host (
    .i_clk(i_clk), .o_rd_en(rd_en), .o_wr_en(wr_en), .o_addr(addr),
    .i_rd_data(rd_data), .i_rd_valid(rd_valid)
  );

  always #50 i_clk = ~i_clk;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic results;
    if (n_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk4(input logic [3:0] g, input logic [3:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    host.rd(a, d, v);
    chk8({7'h00, v}, 8'h01);
    chk8(d, e);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    rdchk(8'h0d, 8'h24);
    rdchk(8'h0e, 8'h24);
    rdchk(8'h0f, 8'h00);
    rdchk(8'h10, 8'h00);
    rdchk(8'h11, 8'h00);
    rdchk(8'h12, 8'h3c);
    rdchk(8'h20, 8'h00);
    chk4(hold, 4'h0);
  endtask

  task automatic t_states;
    for (int c = 0; c < 6; c++) begin
      codes = {3'((c + 4) % 6), 3'((c + 2) % 6), 3'(5 - c), 3'(c)};
      diagnostic_state  = 4'(c * 3);
      step(2);
      rdchk(8'h0d, {3'(c), 3'(5 - c), diagnostic_state[0], diagnostic_state[1]});
      rdchk(8'h0e, {3'((c + 2) % 6), 3'((c + 4) % 6), diagnostic_state[2], diagnostic_state[3]});
    end
  endtask

  task automatic t_chan_mem;
    oc_ev = 4'b0101;
    dc_ev = 4'b0010;
    step(1);
    oc_ev = 4'h0;
    dc_ev = 4'h0;
    chk4(hold, 4'b0111);
    rdchk(8'h0f, 8'ha4);
    rdchk(8'h0f, 8'h00);
    host.wr(8'h0f);
    chk4(hold, 4'b0111);
    // Event still present at the clearing write keeps that channel held
    oc_ev = 4'b1000;
    host.wr(8'h30);
    chk4(hold, 4'b1000);
    rdchk(8'h0f, 8'h10);
    oc_ev = 4'h0;
    rdchk(8'h0f, 8'h10);
    rdchk(8'h0f, 8'h00);
    host.wr(8'h30);
    chk4(hold, 4'h0);
    oc_ev = 4'b0001;
    step(1);
    oc_ev     = 4'h0;
    i_sys_rst = 1'b1;
    step(1);
    i_sys_rst = 1'b0;
    chk4(hold, 4'h0);
    rdchk(8'h0f, 8'h00);
  endtask

  task automatic t_supply_mem;
    for (int b = 0; b < 6; b++) begin
      sup = 6'(1 << b);
      step(1);
      sup = 6'h00;
      rdchk(8'h10, 8'(1 << b));
      rdchk(8'h10, 8'h00);
    end
    sup = 6'h3f;
    step(1);
    sup = 6'h00;
    rdchk(8'h10, 8'h3f);
  endtask

  task automatic t_live;
    logic [6:0] p;
    for (int i = 0; i < 4; i++) begin
      p = (i == 0) ? 7'h55 : (i == 1) ? 7'h2a : (i == 2) ? 7'h7f : 7'h00;
      {warn, flt, sup[5]} = p[6:4];
      sup[3:0] = p[3:0];
      step(2);
      rdchk(8'h11, {p[6:4], 1'b0, p[3:0]});
    end
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    i_clk      = 1'b0;
    i_sys_rst  = 1'b1;
    codes      = 12'h249;
    diagnostic_state       = 4'h0;
    oc_ev      = 4'h0;
    dc_ev      = 4'h0;
    sup        = 6'h00;
    warn       = 1'b0;
    flt        = 1'b0;
    therm      = 8'h3c;
    n_errors   = 0;
    num_checks = 0;
    step(3);
    i_sys_rst = 1'b0;
    t_reset;
    t_states;
    t_chan_mem;
    t_supply_mem;
    t_live;
    results;
  end

  // Whole run needs about 125 cycles; allow far more
  initial begin
    #400000;
    n_errors++;
    results;
  end
endmodule // tb_amp_channel_fault_report_regs
`default_nettype wire
